// *** rtl/codec_mode_ctrl.sv ***
// The Avalon-MM interface to the registers and the address map were left to the implementer.
module codec_mode_ctrl
	import codec_mode_pkg::*;
(
	// Clock; rstn is the power-down pin
	input wire logic ref_clk,
	input wire logic rstn,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Strap and live pins
	input wire mode_pins_t modePins,
	input wire live_pins_t livePins,
	// Serial data out
	output logic serialOut,
	// Audio clocks, two-way
	output logic bitClockOut,
	output logic bitClockOe,
	output logic chanClockOut,
	output logic chanClockOe,
	// Control port pins in serial mode
	output logic ctrlSelN,
	output logic ctrlClock,
	output logic ctrlDataIn,
	output logic ctrlDataOut,
	output logic ctrlDataOe,
	output logic [1:0] ctrlAddr,
	// Mode results for the converters
	output logic clockOutHalf,
	output logic masterClockOut,
	output logic adcPowerDown,
	output logic useCrystal,
	output ratio_t clockRatio,
	output deemph_t deemphMode,
	output logic [1:0] dacFormat,
	output logic [1:0] adcFormat,
	output logic dacFromAdc,
	output logic dacFromFirst,
	output logic [4:0] adcWordBits,
	output logic [4:0] dacWordBits,
	output logic [NUM_DAC*5-1:0] attLevels
);

	// ----------------------------------------
	// Decode functions
	// ----------------------------------------

	// Master clock ratio from select pins and speed
	function automatic ratio_t ratioOf(input logic [1:0] sel,
		input logic dbl);
		ratio_t r;
		r = dbl ? R128 : R256;
		if (sel == 2'h1)
			r = dbl ? R192 : R384;
		else if (sel == 2'h2)
			r = dbl ? R256 : R512;
		else if (sel == 2'h3)
			r = R256;
		return r;
	endfunction

	// Master clocks per bit clock (bit clock is 64fs)
	function automatic logic [3:0] bitDivOf(input ratio_t r);
		logic [3:0] v;
		v = 4'h4;
		if (r == R128)
			v = 4'h2;
		else if (r == R192)
			v = 4'h3;
		else if (r == R384)
			v = 4'h6;
		else if (r == R512)
			v = 4'h8;
		return v;
	endfunction

	// De-emphasis from speed and 2-bit code
	function automatic deemph_t deemphOf(input logic dbl,
		input logic [1:0] code);
		deemph_t m;
		m = DE_OFF;
		if (dbl)
		begin
			if (code == 2'h2)
				m = DE_96K;
		end
		else if (code == 2'h0)
			m = DE_44K;
		else if (code == 2'h2)
			m = DE_48K;
		else if (code == 2'h3)
			m = DE_32K;
		return m;
	endfunction

	// ----------------------------------------
	// Synchronised pins
	// ----------------------------------------
	mode_pins_t pins;
	live_pins_t live;

	pin_sync #(.W($bits(mode_pins_t))) u_mode_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.d(modePins),
		.q(pins)
	);

	pin_sync #(.W($bits(live_pins_t))) u_live_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.d(livePins),
		.q(live)
	);

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	mode_reg_t modeReg;
	logic [4:0] att [NUM_DAC];
	logic [4:0] wordReg;
	logic ctrlOutReg;

	// Effective settings; the register side only counts in serial mode
	wire serialMode = !pins.parallel;
	wire sdosEff = pins.output_source_select | (serialMode & modeReg.output_source_select);
	wire ocksEff = pins.clock_out_divide_select | (serialMode & modeReg.clock_out_divide_select);
	wire dfsEff = pins.double_speed_select | (serialMode & modeReg.double_speed_select);
	wire dem1Eff = pins.deemph_sel_hi | (serialMode & modeReg.deemph_sel_hi);
	wire dem0Eff = pins.deemph_sel_lo | (serialMode & modeReg.deemph_sel_lo);
	wire ratio_t ratioEff = ratioOf(pins.ratioSel, dfsEff);
	wire deemph_t deemphEff = deemphOf(dfsEff, {dem1Eff, dem0Eff});

	// Format and loopback: pins in parallel, register in serial mode
	wire [1:0] fmtEff = serialMode ? modeReg.fmt : pins.fmt;
	wire adcLoopEff = serialMode ? modeReg.adcLoop : pins.adcLoop;
	wire firstFanEff = serialMode ? modeReg.firstFan : pins.firstFan;

	// ADC cannot shift out LSB-justified, falls back to MSB-justified
	wire [1:0] adcFmtEff = (fmtEff == FMT_LSB) ? 2'h0 : fmtEff;

	// ----------------------------------------
	// Avalon decode
	// ----------------------------------------
	wire busReq = read | write;
	wire takeNow = busReq & !waitrequest;
	wire hitMode = (address == OFS_MODE);
	wire hitStat = (address == OFS_STAT);
	wire hitWord = (address == OFS_WORD);
	wire hitCtlo = (address == OFS_CTLO);
	wire [ADDR_W-1:0] attOfs = address - OFS_ATT0;
	wire hitAtt = (address >= OFS_ATT0) &&
		(attOfs < ADDR_W'(NUM_DAC * 4)) && (attOfs[1:0] == 2'h0);
	wire [2:0] attIdx = attOfs[4:2];

	stat_t stat;
	assign stat.chipAddr = serialMode ? pins.chipAddr : 2'h0;
	assign stat.ratio = ratioEff;
	assign stat.deemph = deemphEff;
	assign stat.output_source_select = sdosEff;
	assign stat.osc = pins.osc;
	assign stat.adcPd = dfsEff;
	assign stat.master = pins.master;
	assign stat.serial = serialMode;

	// Read mux; unmapped reads return zero
	logic [31:0] rdMux;
	always_comb
	begin
		rdMux = 32'h0000_0000;
		if (hitMode)
			rdMux = 32'(modeReg);
		else if (hitStat)
			rdMux = 32'(stat);
		else if (hitWord)
			rdMux = 32'(wordReg);
		else if (hitCtlo)
			rdMux = 32'(ctrlOutReg);
		else if (hitAtt)
			rdMux = 32'(att[attIdx]);
	end

	// One wait cycle per access: waitrequest drops the cycle after
	// the request shows, and read data is loaded on that same edge
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			waitrequest <= 1'b1;
			readdata <= 32'h0000_0000;
		end
		else
		begin
			waitrequest <= !(busReq & waitrequest);
			if (read & waitrequest)
				readdata <= rdMux;
		end
	end

	// Register writes; power-down holds all at defaults
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			modeReg <= '0;
			wordReg <= DAC_MAX_BITS;
			ctrlOutReg <= 1'b0;
			for (int i = 0; i < NUM_DAC; i++)
				att[i] <= 5'h00;
		end
		else if (takeNow & write)
		begin
			if (hitMode)
				modeReg <= mode_reg_t'(writedata[$bits(mode_reg_t)-1:0]);
			else if (hitWord)
				wordReg <= writedata[4:0];
			else if (hitCtlo)
				ctrlOutReg <= writedata[0];
			else if (hitAtt)
				att[attIdx] <= writedata[4:0];
		end
	end

	// ----------------------------------------
	// Attenuation outputs
	// ----------------------------------------

	// Codes past the last level clamp to it, keeping 21 levels 1 dB apart
	genvar g;
	generate
		for (g = 0; g < NUM_DAC; g++)
		begin : g_att
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					attLevels[g*5 +: 5] <= 5'h00;
				else if (att[g] > ATT_MAX)
					attLevels[g*5 +: 5] <= ATT_MAX;
				else
					attLevels[g*5 +: 5] <= att[g];
			end
		end
	endgenerate

	// ----------------------------------------
	// Master-mode clock generation
	// ----------------------------------------
	logic [3:0] bitCnt;
	logic [5:0] bitIdx;
	wire [3:0] bitDiv = bitDivOf(ratioEff);
	wire bitWrap = (bitCnt >= bitDiv - 4'h1);

	// Counters run always; outputs only drive in master mode.
	// Odd ratios give a short high phase, still one edge per bit.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bitCnt <= 4'h0;
			bitIdx <= 6'h00;
		end
		else if (bitWrap)
		begin
			bitCnt <= 4'h0;
			bitIdx <= bitIdx + 6'h01;
		end
		else
			bitCnt <= bitCnt + 4'h1;
	end

	// Audio clocks and their enables
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bitClockOut <= 1'b0;
			chanClockOut <= 1'b0;
			bitClockOe <= 1'b0;
			chanClockOe <= 1'b0;
		end
		else
		begin
			bitClockOut <= (bitCnt < {1'b0, bitDiv[3:1]});
			chanClockOut <= bitIdx[LR_BIT];
			bitClockOe <= pins.master;
			chanClockOe <= pins.master;
		end
	end

	// ----------------------------------------
	// Data path and master clock output
	// ----------------------------------------

	// Output source select; a one-cycle delay buys a clean flop output
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			serialOut <= 1'b0;
			masterClockOut <= 1'b0;
			clockOutHalf <= 1'b0;
		end
		else
		begin
			serialOut <= sdosEff ? live.aux : live.adc;
			clockOutHalf <= ocksEff;
			masterClockOut <= !masterClockOut;
		end
	end

	// ----------------------------------------
	// Control port pin roles
	// ----------------------------------------

	// Pins other than ctrlDataOut read inactive in parallel mode so the port stays idle
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrlSelN <= 1'b1;
			ctrlClock <= 1'b0;
			ctrlDataIn <= 1'b0;
			ctrlDataOut <= 1'b0;
			ctrlDataOe <= 1'b0;
			ctrlAddr <= 2'h0;
		end
		else
		begin
			ctrlSelN <= serialMode ? pins.fmt[0] : 1'b1;
			ctrlClock <= serialMode & pins.fmt[1];
			ctrlDataIn <= serialMode & pins.adcLoop;
			ctrlDataOut <= ctrlOutReg;
			ctrlDataOe <= serialMode & !pins.fmt[0];
			ctrlAddr <= serialMode ? pins.chipAddr : 2'h0;
		end
	end

	// ----------------------------------------
	// Mode results
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			adcPowerDown <= 1'b0;
			useCrystal <= 1'b0;
			clockRatio <= R256;
			deemphMode <= DE_OFF;
			dacFormat <= 2'h0;
			adcFormat <= 2'h0;
			dacFromAdc <= 1'b0;
			dacFromFirst <= 1'b0;
			adcWordBits <= ADC_BITS;
			dacWordBits <= DAC_MAX_BITS;
		end
		else
		begin
			adcPowerDown <= dfsEff;
			useCrystal <= pins.osc;
			clockRatio <= ratioEff;
			deemphMode <= deemphEff;
			dacFormat <= fmtEff;
			adcFormat <= adcFmtEff;
			dacFromAdc <= adcLoopEff;
			dacFromFirst <= firstFanEff;
			adcWordBits <= ADC_BITS;
			// Longer words than the converter takes are clamped
			dacWordBits <= (wordReg > DAC_MAX_BITS) ?
				DAC_MAX_BITS : wordReg;
		end
	end

endmodule

// *** rtl/codec_mode_pkg.sv ***
package codec_mode_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_MODE = 6'h00;
	localparam logic [5:0] OFS_STAT = 6'h04;
	localparam logic [5:0] OFS_ATT0 = 6'h08;
	localparam logic [5:0] OFS_WORD = 6'h20;
	localparam logic [5:0] OFS_CTLO = 6'h24;
	localparam logic [5:0] ATT_STRIDE = 6'h04;

	// ----------------------------------------
	// Sizes and limits
	// ----------------------------------------
	localparam int NUM_DAC = 6;
	localparam logic [4:0] ATT_MAX = 5'h14;
	localparam logic [4:0] ADC_BITS = 5'h14;
	localparam logic [4:0] DAC_MAX_BITS = 5'h18;
	localparam logic [1:0] FMT_LSB = 2'h1;
	localparam logic [1:0] DEEMPH_RST = 2'h0;
	localparam int LR_BIT = 5;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {R128, R192, R256, R384, R512} ratio_t;
	typedef enum logic [2:0] {DE_OFF, DE_32K, DE_44K, DE_48K, DE_96K}
		deemph_t;

	// Software mode register, output_source_select in bit 0
	typedef struct packed {
		logic firstFan;
		logic adcLoop;
		logic [1:0] fmt;
		logic deemph_sel_hi;
		logic deemph_sel_lo;
		logic double_speed_select;
		logic clock_out_divide_select;
		logic output_source_select;
	} mode_reg_t;

	// Static strap pins
	typedef struct packed {
		logic output_source_select;
		logic clock_out_divide_select;
		logic double_speed_select;
		logic deemph_sel_hi;
		logic deemph_sel_lo;
		logic master;
		logic osc;
		logic parallel;
		logic [1:0] chipAddr;
		logic [1:0] ratioSel;
		logic [1:0] fmt;
		logic adcLoop;
		logic firstFan;
	} mode_pins_t;

	// Live serial pins
	typedef struct packed {
		logic aux;
		logic adc;
		logic bclk;
		logic channel_clock;
	} live_pins_t;

	// Status register, serial in bit 0
	typedef struct packed {
		logic [1:0] chipAddr;
		ratio_t ratio;
		deemph_t deemph;
		logic output_source_select;
		logic osc;
		logic adcPd;
		logic master;
		logic serial;
	} stat_t;

endpackage

// *** rtl/pin_sync.sv ***
module pin_sync
	import codec_mode_pkg::*;
#(
	parameter int W = 1
)(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Pins in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	// Two-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end

endmodule

// *** tb/audio_far_end.sv ***
module audio_far_end
	import codec_mode_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Clocks from the codec when it is master
	input wire logic bitClockOut,
	input wire logic bitClockOe,
	input wire logic chanClockOut,
	input wire logic chanClockOe,
	// Lines towards the codec
	output live_pins_t livePins
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] cnt;
	// Pattern counter; aux and adc differ so a wrong pick shows
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
			cnt <= 6'h00;
		else
			cnt <= cnt + 6'h01;
	// In slave mode this side makes both clocks, else the wire follows
	assign livePins.aux = cnt[0] ^ cnt[2];
	assign livePins.adc = cnt[1];
	assign livePins.bclk = bitClockOe ? bitClockOut : cnt[1];
	assign livePins.channel_clock = chanClockOe ? chanClockOut : cnt[5];
endmodule

// *** tb/codec_mode_checker_assertions.sv ***
module codec_mode_checker
	import codec_mode_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Bus handshake
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	// Pins
	input wire mode_pins_t modePins,
	input wire live_pins_t livePins,
	// Mode results
	input wire logic serialOut,
	input wire logic bitClockOe,
	input wire logic chanClockOe,
	input wire logic [1:0] ctrlAddr,
	input wire logic clockOutHalf,
	input wire logic adcPowerDown,
	input wire logic useCrystal,
	input wire logic [1:0] adcFormat,
	input wire logic [4:0] adcWordBits
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Pin to output relations
	// ----------------------------------------
	logic [2:0] up;
	logic ok;
	// Pin history from before reset release is not trusted, so wait it out
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
			up <= 3'h0;
		else if (up != 3'h7)
			up <= up + 3'h1;
	assign ok = up == 3'h7;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	chk_serial_source: assert property (ok && $past(modePins.output_source_select, 3)
		|-> serialOut == $past(livePins.aux, 3)) else $error("aux not routed");
	chk_clock_half: assert property (ok && $past(modePins.clock_out_divide_select, 3)
		|-> clockOutHalf) else $error("clock divide pin ignored");
	chk_adc_off: assert property (ok && $past(modePins.double_speed_select, 3)
		|-> adcPowerDown) else $error("adc not powered down");
	chk_role_drive: assert property (ok |-> bitClockOe ==
		$past(modePins.master, 3) && chanClockOe == bitClockOe)
		else $error("clock drive does not follow role");
	chk_osc_pick: assert property (ok |->
		useCrystal == $past(modePins.osc, 3)) else $error("bad clock source");
	chk_addr_mode: assert property (ok |-> ctrlAddr ==
		($past(modePins.parallel, 3) ? 2'h0 : $past(modePins.chipAddr, 3)))
		else $error("chip address misused");
	chk_one_wait: assert property ((read || write) && waitrequest
		|=> !waitrequest) else $error("bus answer late");
	chk_wait_ends: assert property (!waitrequest |=> waitrequest)
		else $error("wait low too long");
	chk_reset_state: assert property (disable iff (1'b0) !rstn
		|-> waitrequest && !adcPowerDown) else $error("not held at default");
	chk_adc_words: assert property (adcFormat != FMT_LSB
		&& adcWordBits == ADC_BITS) else $error("bad adc word format");
	// Main scenarios
	cover property (ok && modePins.master);
	cover property (read && !waitrequest);
	cover property (write && !waitrequest);
endmodule

// *** tb/codec_mode_pin_control_bench.sv ***
module codec_mode_pin_control_bench
	import codec_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rstn, read, write, waitrequest, serialOut;
	logic [ADDR_W-1:0] address;
	logic [31:0] writedata, readdata, rdv;
	mode_pins_t modePins, p;
	live_pins_t livePins;
	logic bitClockOut, bitClockOe, chanClockOut, chanClockOe, ctrlSelN;
	logic ctrlClock, ctrlDataIn, ctrlDataOut, ctrlDataOe, clockOutHalf;
	logic masterClockOut, adcPowerDown, useCrystal, dacFromAdc, dacFromFirst;
	logic [1:0] ctrlAddr, dacFormat, adcFormat;
	ratio_t clockRatio;
	deemph_t deemphMode;
	logic [4:0] adcWordBits, dacWordBits;
	logic [NUM_DAC*5-1:0] attLevels;
	logic [2:0] auxD, adcD;
	logic m;
	logic b;
	int n, h, w;
	int err_count, compares, cyc;
	codec_mode_ctrl dut (.*);
	audio_far_end far (.*);
	// ----------------------------------------
	// Clock, history and timeout
	// ----------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Pin history lets serial output be compared three edges late
	always @(posedge ref_clk)
	begin
		auxD <= {auxD[1:0], livePins.aux};
		adcD <= {adcD[1:0], livePins.adc};
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_count++;
			test_done;
		end
	end
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Holds the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		@(posedge ref_clk);
		while (waitrequest !== 1'b0)
			@(posedge ref_clk);
		rdv = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	// This task changes straps only under reset, as the host must arrange
	task automatic strap(input mode_pins_t v);
		@(posedge ref_clk);
		modePins <= v;
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask
	function automatic ratio_t expRatio(input logic [1:0] s, input logic d);
		case (s)
			2'h0: return d ? R128 : R256;
			2'h1: return d ? R192 : R384;
			2'h2: return d ? R256 : R512;
			default: return R256;
		endcase
	endfunction
	function automatic deemph_t expDem(input logic [1:0] c, input logic d);
		if (d)
			return (c == 2'h2) ? DE_96K : DE_OFF;
		case (c)
			2'h0: return DE_44K;
			2'h1: return DE_OFF;
			2'h2: return DE_48K;
			default: return DE_32K;
		endcase
	endfunction
	// Master-mode bit clock runs at 64fs, so ref clocks per bit is ratio/64
	function automatic int expDiv(input ratio_t r);
		case (r)
			R128: return 2;
			R192: return 3;
			R384: return 6;
			R512: return 8;
			default: return 4;
		endcase
	endfunction
	task automatic test_done;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		rstn = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 6'h00;
		writedata = 32'h0;
		modePins = '0;
		err_count = 0;
		compares = 0;
		cyc = 0;
		// Falls after every flop process waits, so none misses the edge
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check("dacbits", dacWordBits, DAC_MAX_BITS);
		check("ratio", clockRatio, R256);
		check("deemph", deemphMode, DE_OFF);
		rstn <= 1'b1;
		$display("test reset done");
		for (int i = 0; i < 16; i++)
		begin
			p = '0;
			p.parallel = 1'b1;
			p.double_speed_select = i[3];
			p.ratioSel = i[1:0];
			{p.deemph_sel_hi, p.deemph_sel_lo} = i[2:1];
			{p.master, p.osc, p.clock_out_divide_select, p.output_source_select} = i[3:0];
			p.fmt = i[2:1];
			{p.adcLoop, p.firstFan, p.chipAddr} = i[3:0];
			strap(p);
			check("ratio", clockRatio, expRatio(p.ratioSel, p.double_speed_select));
			check("deemph", deemphMode, expDem(i[2:1], p.double_speed_select));
			check("dacfmt", dacFormat, p.fmt);
			check("adcfmt", adcFormat, p.fmt == FMT_LSB ? 2'h0 : p.fmt);
			check("loop", dacFromAdc, p.adcLoop);
			check("fan", dacFromFirst, p.firstFan);
			check("xtal", useCrystal, p.osc);
			check("drive", bitClockOe, p.master);
			check("half", clockOutHalf, p.clock_out_divide_select);
			check("adcpd", adcPowerDown, p.double_speed_select);
			check("addr", ctrlAddr, 2'h0);
			check("sel", ctrlSelN, 1'b1);
			check("sdo", serialOut, p.output_source_select ? auxD[2] : adcD[2]);
			m = masterClockOut;
			@(posedge ref_clk);
			check("mclk", masterClockOut, !m);
			// Count bit clock rises over whole periods in master mode
			if (p.master)
			begin
				w = (i == 8) ? 128 : 48;
				n = 0;
				h = 0;
				b = bitClockOut;
				repeat (w)
				begin
					@(posedge ref_clk);
					n += int'(bitClockOut && !b);
					h += int'(chanClockOut);
					b = bitClockOut;
				end
				check("bclk", n, w / expDiv(expRatio(p.ratioSel, p.double_speed_select)));
				if (i == 8)
					check("channel_clock", h, 64);
			end
			bus(1'b0, OFS_MODE, 32'h0);
			check("mode", rdv, 32'h0);
		end
		$display("test parallel done");
		p = '0;
		p.chipAddr = 2'h2;
		p.fmt = 2'h2;
		p.adcLoop = 1'b1;
		strap(p);
		check("addr", ctrlAddr, 2'h2);
		check("cs", {ctrlSelN, ctrlClock, ctrlDataIn, ctrlDataOe}, 4'h7);
		bus(1'b0, OFS_STAT, 32'h0);
		check("serial", rdv[0], 1'b1);
		bus(1'b1, OFS_MODE, 32'h17);
		repeat (4) @(posedge ref_clk);
		check("or", {clockOutHalf, adcPowerDown}, 2'h3);
		check("deemph", deemphMode, DE_96K);
		bus(1'b0, OFS_STAT, 32'h0);
		check("output_source_select", rdv[4], 1'b1);
		bus(1'b1, OFS_MODE, 32'h08);
		modePins.deemph_sel_hi <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check("deemph", deemphMode, DE_32K);
		bus(1'b1, OFS_CTLO, 32'h1);
		repeat (2) @(posedge ref_clk);
		check("cdo", ctrlDataOut, 1'b1);
		$display("test serial done");
		bus(1'b0, OFS_WORD, 32'h0);
		check("word", rdv, 32'h18);
		bus(1'b1, OFS_WORD, 32'h1E);
		repeat (2) @(posedge ref_clk);
		check("wmax", dacWordBits, DAC_MAX_BITS);
		bus(1'b1, OFS_WORD, 32'h10);
		repeat (2) @(posedge ref_clk);
		check("w16", dacWordBits, 5'h10);
		bus(1'b1, OFS_ATT0, 32'h7);
		bus(1'b1, 6'h1C, 32'h19);
		repeat (2) @(posedge ref_clk);
		check("att0", attLevels[4:0], 5'h07);
		check("att5", attLevels[29:25], ATT_MAX);
		bus(1'b1, 6'h3C, 32'hFF);
		bus(1'b0, 6'h3C, 32'h0);
		check("unmapped", rdv, 32'h0);
		bus(1'b0, OFS_MODE, 32'h0);
		check("mode", rdv, 32'h08);
		$display("test registers done");
		test_done;
	end
endmodule
bind codec_mode_ctrl codec_mode_checker chk (.*);
